// ==== design/sfr_bank.sv ====
// How it works
// - reading serial 0 buffer returns the receive register
// - serial 1 buffer works the same at its own address
// - enable a bit 7 gates timer 2 overflow request
// - enable a bit 6 gates the OR of three spi flags
// - enable a bit 5 gates the brake fault request
// - enable a bit 4 gates the watchdog request
// - enable a bit 3 gates the pwm request
// - enable a bit 2 gates the OR of three capture flags
// - enable a bit 1 gates the OR of pin event flags
// - enable a bit 0 gates i2c event or timeout
// - enable b bit 2 gates wake-up timer request
// - enable b bit 1 gates timer 3 overflow request
// - enable b bit 0 gates serial 1 transmit or receive done
// - programming fault flag set on bad trigger, cleared only by software
// - programming enable bit turns on fast internal oscillator
// - boot select bit picks application or loader flash after reset
// - serial 0 transmit done flag set when frame finishes, software clears
`timescale 1ns/100ps
`include "sfr_params.svh"
module sfr_bank #(
    parameter int BAUD_DIV = `SFR_BAUD_DIV
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // ahb-lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    // serial receive bytes from the ports
    input wire logic rx0_load_i,
    input wire sfr_pkg::sfr_byte_t rx0_data_i,
    input wire logic rx1_load_i,
    input wire sfr_pkg::sfr_byte_t rx1_data_i,
    // serial transmit lines
    output logic txd0_o,
    output logic txd1_o,
    // peripheral request flags
    input wire logic timer2_overflow_flag_i,
    input wire logic spi_done_flag_i,
    input wire logic spi_overrun_flag_i,
    input wire logic mode_fault_flag_i,
    input wire logic brake_fault_flag_i,
    input wire logic watchdog_flag_i,
    input wire logic pwm_period_flag_i,
    input wire logic [2:0] capture_flags_i,
    input wire sfr_pkg::sfr_byte_t pin_event_flags_i,
    input wire logic i2c_event_flag_i,
    input wire logic i2c_timeout_flag_i,
    input wire logic wakeup_timer_flag_i,
    input wire logic timer3_overflow_flag_i,
    input wire logic serial1_rx_done_i,
    // gated requests to interrupt controller
    output sfr_pkg::sfr_irq_vec_t irq_req_o,
    // flash programming
    input wire logic flash_prog_trigger_i,
    input wire logic addr_oversize_i,
    input wire logic cmd_invalid_i,
    input wire logic block_disabled_i,
    input wire logic below_bod_i,
    input wire logic bod_protect_i,
    output logic flash_prog_enable_o,
    output logic fast_osc_en_o,
    output logic boot_from_loader_o
);
    import sfr_pkg::*;

    localparam int TX_BOUND = `SFR_FRAME_BITS * BAUD_DIV + 4;

    sfr_phase_t phase;
    sfr_phase_t next_phase;
    logic take;
    logic [7:0] idx_q;
    logic hit_q;
    logic wr_stb;
    sfr_byte_t wr_byte;
    sfr_byte_t rd_mux;
    sfr_byte_t tx0_buf;
    sfr_byte_t tx1_buf;
    sfr_byte_t rx0_reg;
    sfr_byte_t rx1_reg;
    sfr_byte_t eie_a;
    logic [`SFR_EIEB_W-1:0] eie_b;
    logic prog_fault;
    logic boot_sel;
    logic prog_en;
    logic tx0_done_flag;
    logic tx1_done_flag;
    logic fault_hit;
    logic [1:0] tx_busy;
    logic [1:0] tx_done;
    logic [1:0] txd;
    sfr_irq_vec_t irq_src;
    sfr_irq_vec_t irq_en;

    // bus handshake: reads take one wait state so read data comes from flops
    assign take = hsel_i && hready_i && htrans_i[1];
    assign hreadyout_o = (phase != SFR_PH_RDWAIT);
    assign hresp_o = `SFR_HRESP_OKAY;
    assign wr_stb = (phase == SFR_PH_WRITE) && hit_q;
    assign wr_byte = hwdata_i[7:0];

    // next bus phase
    always_comb begin
        next_phase = SFR_PH_IDLE;
        case (phase)
            SFR_PH_IDLE, SFR_PH_WRITE, SFR_PH_RDOUT: begin
                if (take) begin
                    next_phase = hwrite_i ? SFR_PH_WRITE : SFR_PH_RDWAIT;
                end
            end
            SFR_PH_RDWAIT: begin
                next_phase = SFR_PH_RDOUT;
            end
            default: begin
                next_phase = SFR_PH_IDLE;
            end
        endcase
    end

    // phase register
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            phase <= SFR_PH_IDLE;
        end else begin
            phase <= next_phase;
        end
    end

    // address phase capture
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            idx_q <= `SFR_RST_BYTE;
            hit_q <= 1'b0;
        end else if (take) begin
            idx_q <= haddr_i[`SFR_IDX_MSB:`SFR_IDX_LSB];
            hit_q <= (haddr_i[31:`SFR_HI_LSB] == `SFR_HI_ZERO);
        end
    end

    // read mux, unmapped reads zero
    always_comb begin
        rd_mux = `SFR_RST_BYTE;
        if (hit_q) begin
            case (idx_q)
                `SFR_IDX_SER0: rd_mux = rx0_reg;
                `SFR_IDX_SER1: rd_mux = rx1_reg;
                `SFR_IDX_EIEA: rd_mux = eie_a;
                `SFR_IDX_EIEB: rd_mux = {5'h00, eie_b};
                `SFR_IDX_CHIP: rd_mux = {1'b0, prog_fault, 4'h0, boot_sel, prog_en};
                `SFR_IDX_SSTAT: rd_mux = {4'h0, tx_busy[1], tx1_done_flag, tx_busy[0], tx0_done_flag};
                default: rd_mux = `SFR_RST_BYTE;
            endcase
        end
    end

    // read data register, loaded in the wait state
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            hrdata_o <= '0;
        end else if (phase == SFR_PH_RDWAIT) begin
            hrdata_o <= {`SFR_RD_PAD, rd_mux};
        end
    end

    // transmit buffers hold the last written byte
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tx0_buf <= `SFR_RST_BYTE;
            tx1_buf <= `SFR_RST_BYTE;
        end else if (wr_stb) begin
            if (idx_q == `SFR_IDX_SER0) begin
                tx0_buf <= wr_byte;
            end
            if (idx_q == `SFR_IDX_SER1) begin
                tx1_buf <= wr_byte;
            end
        end
    end

    // receive registers, separate from the transmit side
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rx0_reg <= `SFR_RST_BYTE;
            rx1_reg <= `SFR_RST_BYTE;
        end else begin
            if (rx0_load_i) begin
                rx0_reg <= rx0_data_i;
            end
            if (rx1_load_i) begin
                rx1_reg <= rx1_data_i;
            end
        end
    end

    // one shifter per serial port, started only by a buffer write
    generate
        for (genvar ch = 0; ch < 2; ch++) begin : g_tx
            sfr_tx_if txc();
            assign txc.load = wr_stb && (idx_q == ((ch == 0) ? `SFR_IDX_SER0 : `SFR_IDX_SER1));
            assign txc.data = wr_byte;
            assign tx_busy[ch] = txc.busy;
            assign tx_done[ch] = txc.done;
            sfr_serial_tx #(.BAUD_DIV(BAUD_DIV)) u_tx (
                .clk_i(clk_i),
                .nrst_i(nrst_i),
                .tx(txc.shifter),
                .txd_o(txd[ch])
            );
        end
    endgenerate

    assign txd0_o = txd[0];
    assign txd1_o = txd[1];

    // transmit done flags, write one to clear, a set wins
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tx0_done_flag <= 1'b0;
            tx1_done_flag <= 1'b0;
        end else begin
            if (tx_done[0]) begin
                tx0_done_flag <= 1'b1;
            end else if (wr_stb && idx_q == `SFR_IDX_SSTAT && wr_byte[`SFR_SST_TX0DONE]) begin
                tx0_done_flag <= 1'b0;
            end
            if (tx_done[1]) begin
                tx1_done_flag <= 1'b1;
            end else if (wr_stb && idx_q == `SFR_IDX_SSTAT && wr_byte[`SFR_SST_TX1DONE]) begin
                tx1_done_flag <= 1'b0;
            end
        end
    end

    // enable registers
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            eie_a <= `SFR_RST_BYTE;
            eie_b <= '0;
        end else if (wr_stb) begin
            if (idx_q == `SFR_IDX_EIEA) begin
                eie_a <= wr_byte;
            end
            if (idx_q == `SFR_IDX_EIEB) begin
                eie_b <= wr_byte[`SFR_EIEB_W-1:0];
            end
        end
    end

    // chip control: boot select and programming enable
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            boot_sel <= 1'b0;
            prog_en <= 1'b0;
        end else if (wr_stb && idx_q == `SFR_IDX_CHIP) begin
            boot_sel <= wr_byte[`SFR_CHIP_BOOT];
            prog_en <= wr_byte[`SFR_CHIP_PEN];
        end
    end

    // fault conditions checked when programming is triggered
    assign fault_hit = flash_prog_trigger_i
        && (addr_oversize_i || cmd_invalid_i || block_disabled_i || (below_bod_i && !bod_protect_i));

    // programming fault flag, a set wins over a software clear
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            prog_fault <= 1'b0;
        end else if (fault_hit) begin
            prog_fault <= 1'b1;
        end else if (wr_stb && idx_q == `SFR_IDX_CHIP && !wr_byte[`SFR_CHIP_FAULT]) begin
            prog_fault <= 1'b0;
        end
    end

    assign flash_prog_enable_o = prog_en;
    assign fast_osc_en_o = prog_en;
    assign boot_from_loader_o = boot_sel;

    // request sources, one entry per enable bit
    always_comb begin
        irq_src = '0;
        irq_src[`SFR_IRQ_T2] = timer2_overflow_flag_i;
        irq_src[`SFR_IRQ_SPI] = spi_done_flag_i || spi_overrun_flag_i || mode_fault_flag_i;
        irq_src[`SFR_IRQ_FB] = brake_fault_flag_i;
        irq_src[`SFR_IRQ_WDT] = watchdog_flag_i;
        irq_src[`SFR_IRQ_PWM] = pwm_period_flag_i;
        irq_src[`SFR_IRQ_CAP] = |capture_flags_i;
        irq_src[`SFR_IRQ_PIN] = |pin_event_flags_i;
        irq_src[`SFR_IRQ_I2C] = i2c_event_flag_i || i2c_timeout_flag_i;
        irq_src[`SFR_IRQ_WKT] = wakeup_timer_flag_i;
        irq_src[`SFR_IRQ_T3] = timer3_overflow_flag_i;
        irq_src[`SFR_IRQ_SER1] = tx1_done_flag || serial1_rx_done_i;
    end

    assign irq_en = {eie_b, eie_a};

    // gated requests, registered
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_req_o <= '0;
        end else begin
            irq_req_o <= irq_src & irq_en;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_tx0_start;
        wr_stb && idx_q == `SFR_IDX_SER0 && !tx_busy[0];
    endsequence

    sequence s_tx1_start;
        wr_stb && idx_q == `SFR_IDX_SER1 && !tx_busy[1];
    endsequence

    AST_SER0_START: assert property (s_tx0_start |=> tx_busy[0] ##1 !txd0_o)
        else $error("serial 0 write did not start a frame");
    AST_SER0_ONLY_WRITE: assert property ($rose(tx_busy[0]) |-> $past(wr_stb) && $past(idx_q) == `SFR_IDX_SER0)
        else $error("serial 0 frame started without a buffer write");
    AST_SER0_READ: assert property (phase == SFR_PH_RDWAIT && hit_q && idx_q == `SFR_IDX_SER0
        |=> hreadyout_o && hrdata_o[7:0] == $past(rx0_reg))
        else $error("serial 0 read did not return receive register");
    AST_SER1_START: assert property (s_tx1_start |=> tx_busy[1] ##1 !txd1_o)
        else $error("serial 1 write did not start a frame");
    AST_T2_GATE: assert property (!eie_a[`SFR_IRQ_T2] ##1 !eie_a[`SFR_IRQ_T2] |-> !irq_req_o[`SFR_IRQ_T2])
        else $error("timer 2 request passed while disabled");
    AST_SPI_GATE: assert property (eie_a[`SFR_IRQ_SPI] && mode_fault_flag_i |=> irq_req_o[`SFR_IRQ_SPI])
        else $error("spi mode fault did not raise request");
    AST_CAP_GATE: assert property (eie_a[`SFR_IRQ_CAP] && capture_flags_i[2] |=> irq_req_o[`SFR_IRQ_CAP])
        else $error("capture flag did not raise request");
    AST_IRQ_AND: assert property (##1 irq_req_o == ($past(irq_src) & $past(irq_en)))
        else $error("request vector differs from flags and enables");
    AST_FAULT_SET: assert property (fault_hit |=> prog_fault [*2])
        else $error("programming fault flag not set or not held");
    AST_OSC_ON: assert property (wr_stb && idx_q == `SFR_IDX_CHIP && wr_byte[`SFR_CHIP_PEN]
        |=> fast_osc_en_o && flash_prog_enable_o)
        else $error("fast oscillator not turned on by programming enable");
    AST_BOOT_SEL: assert property (wr_stb && idx_q == `SFR_IDX_CHIP
        |=> boot_from_loader_o == $past(wr_byte[`SFR_CHIP_BOOT]))
        else $error("boot select did not follow write");
    AST_TX0_DONE: assert property (s_tx0_start |-> ##[1:TX_BOUND] tx0_done_flag)
        else $error("serial 0 transmit done flag not set after frame");
    AST_EIEB_ZERO: assert property (phase == SFR_PH_RDWAIT && hit_q && idx_q == `SFR_IDX_EIEB
        |=> hrdata_o[7:3] == 5'h00)
        else $error("unimplemented enable bits read nonzero");
endmodule

// ==== design/sfr_params.svh ====
`ifndef SFR_PARAMS_SVH
`define SFR_PARAMS_SVH

// register indices, byte address is four times the index
`define SFR_IDX_SER0 8'h99
`define SFR_IDX_SER1 8'h9A
`define SFR_IDX_EIEA 8'h9B
`define SFR_IDX_EIEB 8'h9C
`define SFR_IDX_CHIP 8'h9F
`define SFR_IDX_SSTAT 8'hE0

// address slicing of haddr
`define SFR_IDX_LSB 2
`define SFR_IDX_MSB 9
`define SFR_HI_LSB 10
`define SFR_HI_ZERO 22'h00_0000
`define SFR_RD_PAD 24'h00_0000

// reset values
`define SFR_RST_BYTE 8'h00

// second enable register: only bits 2..0 exist
`define SFR_EIEB_MASK 8'h07
`define SFR_EIEB_W 3

// chip control bits
`define SFR_CHIP_SWRST 7
`define SFR_CHIP_FAULT 6
`define SFR_CHIP_BOOT 1
`define SFR_CHIP_PEN 0

// serial status bits
`define SFR_SST_TX0DONE 0
`define SFR_SST_TX0BUSY 1
`define SFR_SST_TX1DONE 2
`define SFR_SST_TX1BUSY 3

// interrupt request vector positions
`define SFR_IRQ_I2C 0
`define SFR_IRQ_PIN 1
`define SFR_IRQ_CAP 2
`define SFR_IRQ_PWM 3
`define SFR_IRQ_WDT 4
`define SFR_IRQ_FB 5
`define SFR_IRQ_SPI 6
`define SFR_IRQ_T2 7
`define SFR_IRQ_SER1 8
`define SFR_IRQ_T3 9
`define SFR_IRQ_WKT 10
`define SFR_IRQ_N 11

// bus encodings
`define SFR_HRESP_OKAY 1'b0

// serial frame: start, eight data, stop
`define SFR_FRAME_BITS 10
`define SFR_BAUD_DIV 16
`define SFR_START_BIT 1'b0
`define SFR_STOP_BIT 1'b1

`endif

// ==== design/sfr_pkg.sv ====
package sfr_pkg;

    // bus phase tracker
    typedef enum logic [3:0] {
        SFR_PH_IDLE = 4'b0001,
        SFR_PH_WRITE = 4'b0010,
        SFR_PH_RDWAIT = 4'b0100,
        SFR_PH_RDOUT = 4'b1000
    } sfr_phase_t;

    // transmit shifter state
    typedef enum logic [1:0] {
        SFR_TX_IDLE = 2'b01,
        SFR_TX_SHIFT = 2'b10
    } sfr_tx_state_t;

    typedef logic [7:0] sfr_byte_t;
    typedef logic [10:0] sfr_irq_vec_t;

endpackage

// ==== design/sfr_serial_tx.sv ====
`timescale 1ns/100ps
`include "sfr_params.svh"
module sfr_serial_tx #(
    parameter int BAUD_DIV = `SFR_BAUD_DIV
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // control from register bank
    sfr_tx_if.shifter tx,
    // serial line
    output logic txd_o
);
    import sfr_pkg::*;

    localparam int DIV_W = $clog2(BAUD_DIV + 1);

    sfr_tx_state_t state;
    logic [`SFR_FRAME_BITS-1:0] shreg;
    logic [DIV_W-1:0] div_cnt;
    logic [3:0] bit_cnt;
    logic bit_end;

    assign bit_end = (div_cnt == DIV_W'(BAUD_DIV - 1));
    assign tx.busy = (state == SFR_TX_SHIFT);

    // frame sequencer, load ignored while a frame is running
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= SFR_TX_IDLE;
            bit_cnt <= '0;
            div_cnt <= '0;
        end else begin
            case (state)
                SFR_TX_IDLE: begin
                    div_cnt <= '0;
                    bit_cnt <= '0;
                    if (tx.load) begin
                        state <= SFR_TX_SHIFT;
                    end
                end
                SFR_TX_SHIFT: begin
                    div_cnt <= bit_end ? '0 : div_cnt + 1'b1;
                    if (bit_end) begin
                        bit_cnt <= bit_cnt + 1'b1;
                        if (bit_cnt == 4'(`SFR_FRAME_BITS - 1)) begin
                            state <= SFR_TX_IDLE;
                        end
                    end
                end
                default: begin
                    state <= SFR_TX_IDLE;
                end
            endcase
        end
    end

    // shift register, lsb first
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            shreg <= '1;
        end else if (state == SFR_TX_IDLE && tx.load) begin
            shreg <= {`SFR_STOP_BIT, tx.data, `SFR_START_BIT};
        end else if (state == SFR_TX_SHIFT && bit_end) begin
            shreg <= {1'b1, shreg[`SFR_FRAME_BITS-1:1]};
        end
    end

    // line output registered, idles high
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            txd_o <= 1'b1;
        end else begin
            txd_o <= (state == SFR_TX_SHIFT) ? shreg[0] : 1'b1;
        end
    end

    // one pulse when the stop bit ends
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tx.done <= 1'b0;
        end else begin
            tx.done <= (state == SFR_TX_SHIFT) && bit_end && (bit_cnt == 4'(`SFR_FRAME_BITS - 1));
        end
    end
endmodule

// ==== design/sfr_tx_if.sv ====
`timescale 1ns/100ps
interface sfr_tx_if;
    import sfr_pkg::*;
    logic load;
    sfr_byte_t data;
    logic busy;
    logic done;

    // register side starts frames, shifter reports back
    modport ctl (output load, output data, input busy, input done);
    modport shifter (input load, input data, output busy, output done);
endinterface

// ==== verification/sfr_bank_tb.sv ====
`timescale 1ns/100ps
`include "sfr_params.svh"
module sfr_bank_tb;
    import sfr_pkg::*;
    localparam int BAUD = 2;
    // fault cases {oversize, invalid, disabled, low, protect}, lowest first
    localparam logic [29:0] FCOND = 30'b00011_00010_00100_01000_10000_00000;
    localparam logic [5:0] FEXP = 6'b011110;
    localparam logic [39:0] REGS = {`SFR_IDX_SER0, `SFR_IDX_SER1, `SFR_IDX_EIEA, `SFR_IDX_EIEB, `SFR_IDX_CHIP};
    logic clk_i, nrst_i, hsel_i, hwrite_i, hreadyout_o, hresp_o;
    logic [31:0] haddr_i, hwdata_i, hrdata_o, rdv;
    logic [1:0] htrans_i;
    logic [2:0] hsize_i, cap_f;
    logic rx0_load_i, rx1_load_i, txd0_o, txd1_o;
    sfr_byte_t rx0_data_i, rx1_data_i, pin_f, txb, rxb, sidx;
    logic t2_f, spi_d, spi_o, mod_f, brk_f, wdt_f, pwm_f, i2c_e, i2c_t, wkt_f, t3_f, s1_rx;
    logic trig, a_ovr, c_inv, b_dis, b_low, b_prt, pen_o, osc_o, boot_o;
    sfr_irq_vec_t irq_req_o;
    int n_fail, checks, cyc, sel_p;
    wire txl = (sel_p == 1) ? txd1_o : txd0_o;

    sfr_bank #(.BAUD_DIV(BAUD)) u_sfr_bank (
        .clk_i(clk_i), .nrst_i(nrst_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
        .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
        .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o),
        .rx0_load_i(rx0_load_i), .rx0_data_i(rx0_data_i), .rx1_load_i(rx1_load_i), .rx1_data_i(rx1_data_i),
        .txd0_o(txd0_o), .txd1_o(txd1_o), .timer2_overflow_flag_i(t2_f), .spi_done_flag_i(spi_d),
        .spi_overrun_flag_i(spi_o), .mode_fault_flag_i(mod_f), .brake_fault_flag_i(brk_f),
        .watchdog_flag_i(wdt_f), .pwm_period_flag_i(pwm_f), .capture_flags_i(cap_f),
        .pin_event_flags_i(pin_f), .i2c_event_flag_i(i2c_e), .i2c_timeout_flag_i(i2c_t),
        .wakeup_timer_flag_i(wkt_f), .timer3_overflow_flag_i(t3_f), .serial1_rx_done_i(s1_rx),
        .irq_req_o(irq_req_o), .flash_prog_trigger_i(trig), .addr_oversize_i(a_ovr), .cmd_invalid_i(c_inv),
        .block_disabled_i(b_dis), .below_bod_i(b_low), .bod_protect_i(b_prt), .flash_prog_enable_o(pen_o),
        .fast_osc_en_o(osc_o), .boot_from_loader_o(boot_o)
    );

    // free running clock
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    function automatic logic [31:0] adr(input logic [7:0] i);
        return {22'h00_0000, i, 2'b00};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic conclude;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // one single word transfer, held until hready is seen high
    task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] wd);
        @(posedge clk_i);
        htrans_i <= 2'b10;
        haddr_i <= a;
        hwrite_i <= w;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        htrans_i <= 2'b00;
        hwdata_i <= wd;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        rdv = hrdata_o;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        bus(a, 1'b0, 32'h0000_0000);
        check(rdv, exp);
    endtask

    // drive request sources; alt picks which flag of an or-group
    task automatic drive_src(input logic [10:0] s, input int alt);
        i2c_e <= s[0] && alt == 0;
        i2c_t <= s[0] && alt != 0;
        pin_f <= s[1] ? 8'h01 << (alt * 3) : 8'h00;
        cap_f <= s[2] ? 3'b001 << alt : 3'b000;
        pwm_f <= s[3];
        wdt_f <= s[4];
        brk_f <= s[5];
        spi_d <= s[6] && alt == 0;
        spi_o <= s[6] && alt == 1;
        mod_f <= s[6] && alt == 2;
        t2_f <= s[7];
        s1_rx <= s[8];
        t3_f <= s[9];
        wkt_f <= s[10];
    endtask

    // find the start bit, then sample each bit in its last cycle
    task automatic frame(input sfr_byte_t b);
        int k;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (txl !== 1'b0 && k < 100);
        @(posedge clk_i);
        check(32'(txl), 32'h0000_0000);
        for (int i = 0; i < 8; i++) begin
            repeat (BAUD) @(posedge clk_i);
            check(32'(txl), 32'(b[i]));
        end
        repeat (BAUD) @(posedge clk_i);
        check(32'(txl), 32'h0000_0001);
    endtask

    // cycle ceiling against hangs
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            conclude();
        end
    end

    // main sequence
    initial begin
        {nrst_i, hwrite_i, rx0_load_i, rx1_load_i, trig, a_ovr, c_inv, b_dis, b_low, b_prt} = '0;
        {haddr_i, hwdata_i, rx0_data_i, rx1_data_i} = '0;
        {n_fail, checks, cyc, sel_p} = '0;
        hsel_i = 1'b1;
        htrans_i = 2'b00;
        hsize_i = 3'b010;
        drive_src(11'h000, 0);
        repeat (16) @(posedge clk_i);
        nrst_i <= 1'b1;
        check(32'(hresp_o), 32'h0000_0000);
        check(32'({pen_o, osc_o, boot_o}), 32'h0000_0000);
        for (int i = 0; i < 5; i++) begin
            rd_chk(adr(REGS[i*8 +: 8]), 32'h0000_0000);
        end
        wr(adr(`SFR_IDX_EIEB), 32'h0000_00FF);
        rd_chk(adr(`SFR_IDX_EIEB), 32'h0000_0007);
        wr(adr(`SFR_IDX_EIEA), 32'h0000_00A5);
        rd_chk(adr(`SFR_IDX_EIEA), 32'h0000_00A5);
        // each enable alone against all sources, then its own source removed
        for (int b = 0; b < 11; b++) begin
            wr(adr(`SFR_IDX_EIEA), b < 8 ? 32'(1 << b) : 32'h0000_0000);
            wr(adr(`SFR_IDX_EIEB), b >= 8 ? 32'(1 << (b - 8)) : 32'h0000_0000);
            for (int alt = 0; alt < 3; alt++) begin
                @(posedge clk_i);
                drive_src(11'h7FF, alt);
                repeat (3) @(posedge clk_i);
                check(32'(irq_req_o), 32'(1 << b));
                drive_src(11'h7FF ^ 11'(1 << b), alt);
                repeat (3) @(posedge clk_i);
                check(32'(irq_req_o), 32'h0000_0000);
            end
        end
        drive_src(11'h000, 0);
        // both serial ports: receive path, transmit frame, done flag
        for (int p = 0; p < 2; p++) begin
            sel_p = p;
            rxb = p ? 8'h5A : 8'h3C;
            txb = p ? 8'hC3 : 8'hA5;
            sidx = p ? `SFR_IDX_SER1 : `SFR_IDX_SER0;
            @(posedge clk_i);
            rx0_load_i <= (p == 0);
            rx1_load_i <= (p == 1);
            rx0_data_i <= rxb;
            rx1_data_i <= rxb;
            @(posedge clk_i);
            rx0_load_i <= 1'b0;
            rx1_load_i <= 1'b0;
            rd_chk(adr(sidx), {24'h00_0000, rxb});
            repeat (8) @(posedge clk_i);
            check(32'(txl), 32'h0000_0001);
            wr(adr(sidx), {24'h00_0000, txb});
            frame(txb);
            repeat (4) @(posedge clk_i);
            rd_chk(adr(`SFR_IDX_SSTAT), p ? 32'h0000_0004 : 32'h0000_0001);
            wr(adr(`SFR_IDX_SSTAT), p ? 32'h0000_0004 : 32'h0000_0001);
            rd_chk(adr(`SFR_IDX_SSTAT), 32'h0000_0000);
            rd_chk(adr(sidx), {24'h00_0000, rxb});
        end
        // chip control: bit 7 and write-one to fault read back zero
        wr(adr(`SFR_IDX_CHIP), 32'h0000_00C3);
        rd_chk(adr(`SFR_IDX_CHIP), 32'h0000_0003);
        check(32'({pen_o, osc_o, boot_o}), 32'h0000_0007);
        for (int c = 0; c < 6; c++) begin
            @(posedge clk_i);
            {a_ovr, c_inv, b_dis, b_low, b_prt} <= FCOND[c*5 +: 5];
            trig <= 1'b1;
            @(posedge clk_i);
            trig <= 1'b0;
            repeat (2) @(posedge clk_i);
            rd_chk(adr(`SFR_IDX_CHIP), FEXP[c] ? 32'h0000_0043 : 32'h0000_0003);
            repeat (4) @(posedge clk_i);
            rd_chk(adr(`SFR_IDX_CHIP), FEXP[c] ? 32'h0000_0043 : 32'h0000_0003);
            wr(adr(`SFR_IDX_CHIP), 32'h0000_0003);
            rd_chk(adr(`SFR_IDX_CHIP), 32'h0000_0003);
        end
        // enable cleared last stops the oscillator
        wr(adr(`SFR_IDX_CHIP), 32'h0000_0000);
        // register updates on the edge that ends the write, look one edge later
        @(posedge clk_i);
        check(32'({pen_o, osc_o, boot_o}), 32'h0000_0000);
        // unmapped index and high address bits are refused
        wr(adr(8'h9D), 32'h0000_00FF);
        rd_chk(adr(8'h9D), 32'h0000_0000);
        rd_chk(32'h0001_0000 | adr(`SFR_IDX_SER0), 32'h0000_0000);
        conclude();
    end
endmodule
